//--- hw/smic_defines.svh
/*
  Offsets, field positions, reset values and timing counts of the supply
  monitor and interrupt controller. Assumes a 100 MHz system clock.
*/
`ifndef SMIC_DEFINES_SVH
`define SMIC_DEFINES_SVH

// ==========================================
// Register offsets on the data memory port
`define SMIC_OFS_PRI0       4'h0
`define SMIC_OFS_PRI1       4'h1
`define SMIC_OFS_PRI2       4'h2
`define SMIC_OFS_SHR0       4'h3
`define SMIC_OFS_SHR1       4'h4
`define SMIC_OFS_SHR2       4'h5
`define SMIC_OFS_SHR3       4'h6
`define SMIC_OFS_EDGE       4'h7
`define SMIC_OFS_MON        4'h8

// ==========================================
// Implemented bit masks
`define SMIC_MSK_PRI0       8'h7F
`define SMIC_MSK_PRI1       8'hFF
`define SMIC_MSK_PRI2       8'hFF
`define SMIC_MSK_SHR0       8'h33
`define SMIC_MSK_SHR1       8'hFF
`define SMIC_MSK_SHR2       8'h77
`define SMIC_MSK_SHR3       8'h33
`define SMIC_MSK_EDGE       8'h0F
`define SMIC_MSK_MON        8'h1F

// ==========================================
// Reset values
`define SMIC_RST_IRQ        8'h00
`define SMIC_RST_EDGE       8'h00
`define SMIC_RST_MON        8'h00

// ==========================================
// Field positions
`define SMIC_BIT_GLOBAL_EN  0
`define SMIC_BIT_LOW_FLAG   5
`define SMIC_BIT_MON_EN     4
`define SMIC_BIT_REF_OUT    3
`define SMIC_THR_MSB        2
`define SMIC_PIN_A_LSB      0
`define SMIC_PIN_B_LSB      2

// ==========================================
// Peripheral event positions
`define SMIC_EVT_TOUCH      0
`define SMIC_EVT_UART       1
`define SMIC_EVT_ADC        2
`define SMIC_EVT_TB0        3
`define SMIC_EVT_TB1        4
`define SMIC_EVT_CTM0P      5
`define SMIC_EVT_CTM0A      6
`define SMIC_EVT_CTM1P      7
`define SMIC_EVT_CTM1A      8
`define SMIC_EVT_STMP       9
`define SMIC_EVT_STMA       10
`define SMIC_EVT_PTMP       11
`define SMIC_EVT_PTMA       12
`define SMIC_EVT_SIM        13
`define SMIC_EVT_EEPROM     14
`define SMIC_EVT_W          15

// ==========================================
// Timing
`define SMIC_CLK_PERIOD_NS  10
`define SMIC_IRQ_DELAY_NS   20000
`define SMIC_IRQ_DELAY_CYC  ((`SMIC_IRQ_DELAY_NS + `SMIC_CLK_PERIOD_NS - 1) / `SMIC_CLK_PERIOD_NS)

`endif

//--- hw/smic_pkg.sv
/*
  Types of the supply monitor and interrupt controller.
  Assumes nothing beyond the constants header.
*/
package smic_pkg;

  // ==========================================
  // Pin edge modes
  typedef enum logic [1:0] {
    SMIC_EDGE_OFF  = 2'b00,
    SMIC_EDGE_RISE = 2'b01,
    SMIC_EDGE_FALL = 2'b10,
    SMIC_EDGE_BOTH = 2'b11
  } smic_edge_mode_type;

  // ==========================================
  // Supply interrupt delay states
  typedef enum logic [1:0] {
    SMIC_SUP_IDLE  = 2'b00,
    SMIC_SUP_COUNT = 2'b01,
    SMIC_SUP_DONE  = 2'b10
  } smic_sup_state_type;

endpackage

//--- hw/smic_edge_if.sv
/*
  Carrier between the controller and one pin edge detector.
  Assumes the pin level is synchronous to the system clock.
*/
interface smic_edge_if;
  import smic_pkg::*;
  logic               pin;
  smic_edge_mode_type mode;
  logic               hit;
  modport detector (input pin, input mode, output hit);
  modport owner    (output pin, output mode, input hit);
endinterface

//--- hw/smic_edge_detect.sv
/*
  Edge detector for one external interrupt pin.
  Assumes the pin is already synchronous to clk.
*/
module smic_edge_detect
  import smic_pkg::*;
(
  // Clock and reset
  input wire logic   clk,
  input wire logic   rst,
  // Controller side
  smic_edge_if.detector eif
);

  logic prev_r;
  logic armed_r;
  logic rise;
  logic fall;

  // Arming avoids a false edge from the reset value of prev_r
  assign rise = armed_r && eif.pin && !prev_r;
  assign fall = armed_r && !eif.pin && prev_r;
  assign eif.hit = (eif.mode == SMIC_EDGE_RISE && rise) || // RULE_16 RULE_17
                   (eif.mode == SMIC_EDGE_FALL && fall) ||
                   (eif.mode == SMIC_EDGE_BOTH && (rise || fall));

  always_ff @(posedge clk) begin
    prev_r  <= rst ? 1'b0 : eif.pin;
    armed_r <= !rst;
  end

  // ==========================================
  // Checks
  default clocking @(posedge clk); endclocking
  default disable iff (rst);

  edge_off_a: assert property (eif.mode == SMIC_EDGE_OFF |-> !eif.hit) // RULE_16
    else $error("edge hit while pin disabled");
  edge_rise_a: assert property (eif.mode == SMIC_EDGE_RISE && $past(armed_r) && $rose(eif.pin)
                                |-> eif.hit) // RULE_17
    else $error("rising edge missed");
  edge_fall_a: assert property (eif.mode == SMIC_EDGE_FALL && eif.hit |-> $fell(eif.pin)) // RULE_17
    else $error("falling mode hit without falling edge");

endmodule

//--- hw/smic_top.sv
/*
  Supply monitor control and interrupt request logic: nine byte registers
  on the data memory port, pin edge detection, multi-function merging,
  delayed supply interrupt, wake request and vector selection.
  Assumes all inputs are synchronous to clk and the core reads the vector
  while irq_req is high.
*/
`include "smic_defines.svh"

//
// Contract
// RULE_01: Monitor register holds read-only low flag, enable, reference output, threshold.
// RULE_02: Threshold code selects one of eight levels, ascending from lowest.
// RULE_03: Monitor runs when enabled; detection switched off when disabled.
// RULE_04: Low flag is one while supply below level, zero otherwise, resets zero.
// RULE_05: Internal reference turns on automatically while monitor is in use.
// RULE_06: Reference output enable bit gates the bandgap output.
// RULE_07: Software waits for settling and tolerates flag chatter near threshold.
// RULE_08: Supply request flag sets only after a fixed delay of low flag.
// RULE_09: Supply interrupt feeds one multi-function interrupt.
// RULE_10: Monitor stays active in power down; supply drop sets request flag.
// RULE_11: Supply interrupt during sleep or idle wakes the device.
// RULE_12: Software presets the supply flag to avoid wake-up.
// RULE_13: Two pin sources and the listed internal peripheral sources.
// RULE_14: Three primary, four multi-function and one edge-select register.
// RULE_15: Every source has its own enable bit and request flag.
// RULE_16: Second pin edge bits 3..2: off, rising, falling, both.
// RULE_17: First pin edge bits 1..0 with the same encoding.
// RULE_18: Unimplemented bits of edge-select and monitor registers read zero.
// RULE_19: Accepted interrupt suspends the main program.
// RULE_20: Flag jumps to vector only when its enable is high.
// RULE_21: Global enable low blocks every interrupt.
// RULE_22: Taking an interrupt pushes return address and loads its vector.
// RULE_23: Flags stay set until software clears; software writes may set them.
module smic_top
  import smic_pkg::*;
#(
  parameter int IRQ_DELAY_CYCLES = `SMIC_IRQ_DELAY_CYC
)(
  // Clock and reset
  input  wire logic                   clk,
  input  wire logic                   rst,
  // Data memory register port
  input  wire logic [3:0]             reg_addr,
  input  wire logic                   reg_wr_en,
  input  wire logic [7:0]             reg_wr_data,
  input  wire logic                   reg_rd_en,
  output logic      [7:0]             reg_rd_data,
  // External pins and peripheral events
  input  wire logic                   ext_irq_pin_a,
  input  wire logic                   ext_irq_pin_b,
  input  wire logic [`SMIC_EVT_W-1:0] periph_evt,
  // Analog monitor
  input  wire logic                   supply_below,
  output logic                        monitor_enable,
  output logic                        reference_enable,
  output logic                        reference_output_enable,
  output logic      [2:0]             threshold_select,
  // Core
  input  wire logic                   sleep_mode,
  output logic                        wake_req,
  output logic                        irq_req,
  output logic      [3:0]             irq_vector
);

  localparam int NREG = 9;
  localparam int NVEC = 11;
  localparam int DW   = $clog2(IRQ_DELAY_CYCLES + 1);

  localparam logic [7:0] REG_MASK [0:NREG-1] = '{
    `SMIC_MSK_PRI0, `SMIC_MSK_PRI1, `SMIC_MSK_PRI2,
    `SMIC_MSK_SHR0, `SMIC_MSK_SHR1, `SMIC_MSK_SHR2, `SMIC_MSK_SHR3,
    `SMIC_MSK_EDGE, `SMIC_MSK_MON
  };

  localparam logic [7:0] REG_RST [0:NREG-1] = '{
    `SMIC_RST_IRQ, `SMIC_RST_IRQ, `SMIC_RST_IRQ,
    `SMIC_RST_IRQ, `SMIC_RST_IRQ, `SMIC_RST_IRQ, `SMIC_RST_IRQ,
    `SMIC_RST_EDGE, `SMIC_RST_MON
  };

  // ==========================================
  // Declarations
  logic [7:0]         regs_r   [0:NREG-1];
  logic [7:0]         reg_nxt  [0:NREG-1];
  logic [7:0]         set_v    [0:NREG-1];
  logic [NREG-1:0]    wr_hit;
  logic [NREG-1:0]    new_set;
  logic [1:0]         pin_hit;
  logic [1:0]         pin_lvl;
  logic [3:0]         mf_any;
  logic [NVEC-1:0]    pend;
  logic               global_en;
  logic               low_flag_r;
  logic               low_flag_nxt;
  logic               sup_set;
  logic [DW-1:0]      dly_cnt_r;
  logic [DW-1:0]      dly_cnt_nxt;
  smic_sup_state_type sup_state_r;
  smic_sup_state_type sup_state_nxt;
  logic [7:0]         mon_rd;
  logic [7:0]         rd_nxt;
  logic [7:0]         rd_data_r;
  logic               ref_on_r;
  logic               wake_r;
  logic               irq_req_r;
  logic [3:0]         irq_vector_r;

  // ==========================================
  // Pin edge detectors
  assign pin_lvl = {ext_irq_pin_b, ext_irq_pin_a};

  for (genvar p = 0; p < 2; p++) begin : g_pin
    smic_edge_if eif ();
    assign eif.pin  = pin_lvl[p];
    assign eif.mode = smic_edge_mode_type'(regs_r[`SMIC_OFS_EDGE][2*p +: 2]); // RULE_16 RULE_17
    assign pin_hit[p] = eif.hit;
    smic_edge_detect u_edge (
      .clk (clk),
      .rst (rst),
      .eif (eif)
    );
  end

  // ==========================================
  // Multi-function merge: any enabled sub-request raises the shared flag
  for (genvar m = 0; m < 4; m++) begin : g_mf
    assign mf_any[m] = |(regs_r[`SMIC_OFS_SHR0 + m][7:4] & regs_r[`SMIC_OFS_SHR0 + m][3:0]); // RULE_09
  end

  // ==========================================
  // Hardware set vectors, flags in the upper nibble
  // Primary group: shared flags are re-set every cycle while an enabled sub-request stands
  assign set_v[`SMIC_OFS_PRI0] = {1'b0, periph_evt[`SMIC_EVT_TOUCH], pin_hit, 4'h0}; // RULE_13 RULE_15
  assign set_v[`SMIC_OFS_PRI1] = {periph_evt[`SMIC_EVT_ADC], mf_any[1], mf_any[0],
                                  periph_evt[`SMIC_EVT_UART], 4'h0};
  assign set_v[`SMIC_OFS_PRI2] = {mf_any[3], periph_evt[`SMIC_EVT_TB1], periph_evt[`SMIC_EVT_TB0],
                                  mf_any[2], 4'h0};

  // Shared group
  assign set_v[`SMIC_OFS_SHR0] = {2'h0, periph_evt[`SMIC_EVT_CTM0A], periph_evt[`SMIC_EVT_CTM0P], 4'h0};
  assign set_v[`SMIC_OFS_SHR1] = {periph_evt[`SMIC_EVT_STMA], periph_evt[`SMIC_EVT_STMP],
                                  periph_evt[`SMIC_EVT_CTM1A], periph_evt[`SMIC_EVT_CTM1P], 4'h0};
  assign set_v[`SMIC_OFS_SHR2] = {1'b0, periph_evt[`SMIC_EVT_SIM], periph_evt[`SMIC_EVT_PTMA],
                                  periph_evt[`SMIC_EVT_PTMP], 4'h0};
  assign set_v[`SMIC_OFS_SHR3] = {2'h0, periph_evt[`SMIC_EVT_EEPROM], sup_set, 4'h0}; // RULE_09 RULE_10

  // Control registers have no hardware set
  assign set_v[`SMIC_OFS_EDGE] = 8'h00;
  assign set_v[`SMIC_OFS_MON]  = 8'h00;

  // ==========================================
  // Register file; a hardware set wins over a clearing write
  for (genvar g = 0; g < NREG; g++) begin : g_reg // RULE_14
    assign wr_hit[g]  = reg_wr_en && (reg_addr == 4'(g));
    assign reg_nxt[g] = wr_hit[g] ? ((reg_wr_data & REG_MASK[g]) | set_v[g]) // RULE_23
                                  : (regs_r[g] | set_v[g]);
    assign new_set[g] = |(set_v[g] & ~regs_r[g]);
    always_ff @(posedge clk) begin
      regs_r[g] <= rst ? REG_RST[g] : reg_nxt[g];
    end
  end

  // ==========================================
  // Supply monitor
  assign monitor_enable          = regs_r[`SMIC_OFS_MON][`SMIC_BIT_MON_EN];  // RULE_03
  assign reference_output_enable = regs_r[`SMIC_OFS_MON][`SMIC_BIT_REF_OUT]; // RULE_06
  assign threshold_select        = regs_r[`SMIC_OFS_MON][`SMIC_THR_MSB:0];   // RULE_02
  assign reference_enable        = ref_on_r;

  // Comparator is ignored while disabled, so the flag cannot stick high
  assign low_flag_nxt = monitor_enable && supply_below; // RULE_03 RULE_04

  always_ff @(posedge clk) begin
    low_flag_r <= rst ? 1'b0 : low_flag_nxt;
    // Loaded from the next value so the reference rises with the enable
    ref_on_r   <= rst ? 1'b0 : reg_nxt[`SMIC_OFS_MON][`SMIC_BIT_MON_EN]; // RULE_05
  end

  // Delay from low flag to request; chatter restarts the wait
  assign sup_set = (sup_state_r == SMIC_SUP_COUNT) && low_flag_r &&
                   (dly_cnt_r == DW'(IRQ_DELAY_CYCLES - 1)); // RULE_08

  always_comb begin
    sup_state_nxt = sup_state_r;
    dly_cnt_nxt   = dly_cnt_r;
    unique case (sup_state_r)
      SMIC_SUP_IDLE: begin
        dly_cnt_nxt = '0;
        if (low_flag_r) begin
          sup_state_nxt = SMIC_SUP_COUNT;
        end
      end
      SMIC_SUP_COUNT: begin
        if (!low_flag_r) begin
          sup_state_nxt = SMIC_SUP_IDLE;
        end else if (sup_set) begin
          sup_state_nxt = SMIC_SUP_DONE; // RULE_08
        end else begin
          dly_cnt_nxt = dly_cnt_r + DW'(1);
        end
      end
      SMIC_SUP_DONE: begin
        if (!low_flag_r) begin
          sup_state_nxt = SMIC_SUP_IDLE;
        end
      end
      default: begin
        sup_state_nxt = SMIC_SUP_IDLE;
      end
    endcase
  end

  always_ff @(posedge clk) begin
    sup_state_r <= rst ? SMIC_SUP_IDLE : sup_state_nxt;
    dly_cnt_r   <= rst ? '0 : dly_cnt_nxt;
  end

  // ==========================================
  // Read path
  assign mon_rd  = {2'b00, low_flag_r, regs_r[`SMIC_OFS_MON][4:0]}; // RULE_01 RULE_18
  assign rd_nxt  = !reg_rd_en                    ? rd_data_r :
                   (reg_addr == `SMIC_OFS_MON)   ? mon_rd :
                   (reg_addr <  `SMIC_OFS_MON)   ? (regs_r[reg_addr[2:0]] & REG_MASK[reg_addr[2:0]]) :
                                                   8'h00;

  always_ff @(posedge clk) begin
    rd_data_r <= rst ? 8'h00 : rd_nxt;
  end
  assign reg_rd_data = rd_data_r;

  // ==========================================
  // Request to the core, lowest vector first
  function automatic logic [3:0] smic_first(input logic [NVEC-1:0] v);
    logic [3:0] idx;
    idx = 4'h0;
    for (int i = NVEC - 1; i >= 0; i--) begin
      if (v[i]) begin
        idx = 4'(i);
      end
    end
    return idx;
  endfunction

  assign global_en = regs_r[`SMIC_OFS_PRI0][`SMIC_BIT_GLOBAL_EN];
  assign pend = {regs_r[`SMIC_OFS_PRI2][7:4] & regs_r[`SMIC_OFS_PRI2][3:0],
                 regs_r[`SMIC_OFS_PRI1][7:4] & regs_r[`SMIC_OFS_PRI1][3:0],
                 regs_r[`SMIC_OFS_PRI0][6:4] & regs_r[`SMIC_OFS_PRI0][3:1]}; // RULE_20

  always_ff @(posedge clk) begin
    irq_req_r    <= rst ? 1'b0 : (global_en && (|pend)); // RULE_19 RULE_21
    irq_vector_r <= rst ? 4'h0 : smic_first(pend);       // RULE_22
    wake_r       <= rst ? 1'b0 : (sleep_mode && (|new_set)); // RULE_11 RULE_12
  end

  assign irq_req    = irq_req_r;
  assign irq_vector = irq_vector_r;
  assign wake_req   = wake_r;

  // ==========================================
  // Checks
  default clocking @(posedge clk); endclocking
  default disable iff (rst);

  logic [DW:0] hold_cnt_r;
  always_ff @(posedge clk) begin
    if (rst || !low_flag_r) begin
      hold_cnt_r <= '0;
    end else if (hold_cnt_r <= (DW+1)'(IRQ_DELAY_CYCLES)) begin
      hold_cnt_r <= hold_cnt_r + (DW+1)'(1);
    end
  end

  sequence mon_write_s;
    reg_wr_en && reg_addr == `SMIC_OFS_MON;
  endsequence

  sequence mon_read_s;
    reg_rd_en && reg_addr == `SMIC_OFS_MON;
  endsequence

  thr_follow_a: assert property (mon_write_s |=> threshold_select == $past(reg_wr_data[2:0]) // RULE_02
                                  && reference_output_enable == $past(reg_wr_data[3]))
    else $error("monitor register write not applied");

  mon_rd_a: assert property (mon_read_s |=> reg_rd_data[7:6] == 2'b00 // RULE_18
                             && reg_rd_data[5] == $past(low_flag_r))
    else $error("monitor register read value wrong");

  rd_unmap_a: assert property (reg_rd_en && reg_addr > `SMIC_OFS_MON |=> reg_rd_data == 8'h00) // RULE_14
    else $error("unmapped read not zero");

  flag_off_a: assert property (!monitor_enable |=> !low_flag_r) // RULE_03
    else $error("low flag high while monitor disabled");

  ref_auto_a: assert property ($rose(monitor_enable) |-> reference_enable) // RULE_05
    else $error("reference not enabled with monitor");

  ref_follow_a: assert property (reference_enable == monitor_enable) // RULE_05
    else $error("reference state differs from monitor enable");

  sup_delay_a: assert property (sup_set |-> hold_cnt_r == (DW+1)'(IRQ_DELAY_CYCLES)) // RULE_08
    else $error("supply request before delay elapsed");

  flag_hold_a: assert property (regs_r[`SMIC_OFS_SHR3][4] && !wr_hit[`SMIC_OFS_SHR3] // RULE_23
                                |=> regs_r[`SMIC_OFS_SHR3][4])
    else $error("supply flag lost without a write");

  set_wins_a: assert property (sup_set && wr_hit[`SMIC_OFS_SHR3] |=> regs_r[`SMIC_OFS_SHR3][4]) // RULE_23
    else $error("hardware set lost to a clearing write");

  mf_merge_a: assert property (regs_r[`SMIC_OFS_SHR3][4] && regs_r[`SMIC_OFS_SHR3][0] // RULE_09
                               |=> regs_r[`SMIC_OFS_PRI2][7])
    else $error("supply request not merged into shared flag");

  global_gate_a: assert property (!global_en |=> !irq_req) // RULE_21
    else $error("request despite global enable low");

  enable_gate_a: assert property (irq_req |-> $past(pend) != '0 && $past(global_en)) // RULE_20
    else $error("request without an enabled flag");

  vec_low_a: assert property (pend[0] |=> irq_vector == 4'h0) // RULE_22
    else $error("first pin request not given the lowest vector");

  wake_sup_a: assert property (sleep_mode && sup_set && !regs_r[`SMIC_OFS_SHR3][4] |=> wake_req) // RULE_11
    else $error("supply event did not wake the device");

  wake_idle_a: assert property (!sleep_mode |=> !wake_req) // RULE_11
    else $error("wake request while awake");


endmodule

//--- verif/smic_far_model.sv
/*
  Far side of the block: the analog supply comparator and the peripheral
  event sources. Assumes the bench changes supply_mv and evt_cmd just
  after a rising clock edge.
*/
module smic_far_model (
  // Clock
  input  wire logic        clk,
  // Monitor controls from the block
  input  wire logic        monitor_enable,
  input  wire logic [2:0]  threshold_select,
  input  wire logic [12:0] supply_mv,
  output logic             supply_below,
  // Event sources
  input  wire logic [14:0] evt_cmd,
  output logic      [14:0] periph_evt
);
  timeunit 1ns;
  timeprecision 1ps;

  // ==========================================
  // Comparator, trip levels in mV, ascending
  logic [12:0] trip_mv [0:7];
  logic        wander_r = 1'b0;
  logic [14:0] cmd_prev_r = 15'h0000;
  assign trip_mv = '{13'h07D0, 13'h0898, 13'h0960, 13'h0A8C,
                     13'h0BB8, 13'h0CE4, 13'h0E10, 13'h0FA0};
  always @(posedge clk) begin
    wander_r <= ~wander_r;
    cmd_prev_r <= evt_cmd;
  end
  // Detector off: output is meaningless, so it wanders
  wire logic below_w = supply_mv < trip_mv[threshold_select];
  assign supply_below = monitor_enable ? below_w : wander_r;

  // ==========================================
  // One pulse per command rise
  assign periph_evt = evt_cmd & ~cmd_prev_r;
endmodule

//--- verif/test_supply_monitor_interrupt_ctrl.sv
/*
  Self-checking bench of the supply monitor and interrupt controller.
  Assumes the far-side model and a 100 MHz clock; delay shortened to 4.
*/
module test_supply_monitor_interrupt_ctrl;
  timeunit 1ns;
  timeprecision 1ps;
  localparam int DLY = 4;

  logic        clk = 1'b0;
  logic        rst = 1'b1;
  logic [3:0]  reg_addr = 4'h0;
  logic        reg_wr_en = 1'b0;
  logic [7:0]  reg_wr_data = 8'h00;
  logic        reg_rd_en = 1'b0;
  logic [7:0]  reg_rd_data;
  logic [1:0]  pins = 2'h0;
  logic [14:0] evt_cmd = 15'h0000;
  logic [14:0] periph_evt;
  logic [12:0] supply_mv = 13'h1388;
  logic        supply_below;
  logic        sleep_mode = 1'b0;
  logic [5:0]  mon_out;
  logic        wake_req;
  logic        irq_req;
  logic [3:0]  irq_vector;
  int          err_count = 0;
  int          total_checks = 0;
  int          cyc = 0;
  int          wake_cnt = 0;

  smic_top #(.IRQ_DELAY_CYCLES(DLY)) u_smic_top (
    .clk(clk), .rst(rst), .reg_addr(reg_addr), .reg_wr_en(reg_wr_en),
    .reg_wr_data(reg_wr_data), .reg_rd_en(reg_rd_en), .reg_rd_data(reg_rd_data),
    .ext_irq_pin_a(pins[0]), .ext_irq_pin_b(pins[1]), .periph_evt(periph_evt),
    .supply_below(supply_below), .monitor_enable(mon_out[5]), .reference_enable(mon_out[4]),
    .reference_output_enable(mon_out[3]), .threshold_select(mon_out[2:0]),
    .sleep_mode(sleep_mode), .wake_req(wake_req), .irq_req(irq_req), .irq_vector(irq_vector));

  smic_far_model u_smic_far_model (
    .clk(clk), .monitor_enable(mon_out[5]), .threshold_select(mon_out[2:0]),
    .supply_mv(supply_mv), .supply_below(supply_below), .evt_cmd(evt_cmd), .periph_evt(periph_evt));

  // ==========================================
  // Clock, timeout and wake pulse count
  initial begin
    forever #5 clk = ~clk;
  end
  always @(posedge clk) begin
    cyc++;
    if (wake_req === 1'b1) wake_cnt++;
    // Whole run needs a few hundred cycles
    if (cyc == 20000) begin
      err_count++;
      print_verdict();
    end
  end

  // ==========================================
  // Shared tasks
  task automatic print_verdict();
    $display("checks %0d mismatches %0d", total_checks, err_count);
    if (err_count == 0 && total_checks > 0) $display("Regression OK");
    else $display("Regression broken");
    $finish;
  endtask
  task automatic chk(input logic [7:0] got, input logic [7:0] exp, input string what);
    total_checks++;
    if (got !== exp) begin
      err_count++;
      $display("ERROR %0t %s got %h exp %h", $time, what, got, exp);
    end
  endtask
  task automatic wr(input logic [3:0] a, input logic [7:0] d);
    @(posedge clk);
    reg_addr <= a;
    reg_wr_data <= d;
    reg_wr_en <= 1'b1;
    @(posedge clk);
    reg_wr_en <= 1'b0;
  endtask
  task automatic rdchk(input logic [3:0] a, input logic [7:0] exp, input string what);
    @(posedge clk);
    reg_addr <= a;
    reg_rd_en <= 1'b1;
    @(posedge clk);
    reg_rd_en <= 1'b0;
    #1 chk(reg_rd_data, exp, what);
  endtask
  task automatic fire(input int e);
    @(posedge clk);
    evt_cmd <= 15'h0001 << e;
    @(posedge clk);
    evt_cmd <= 15'h0000;
  endtask
  task automatic idle(input int n);
    repeat (n) @(posedge clk);
  endtask

  // ==========================================
  // Scenarios
  task automatic t_reset();
    for (int i = 0; i < 16; i++) rdchk(i[3:0], 8'h00, "reset or unmapped");
    $display("done reset");
  endtask

  task automatic t_masks();
    logic [7:0] msk [0:8];
    msk = '{8'h7F, 8'hFF, 8'hFF, 8'h33, 8'hFF, 8'h77, 8'h33, 8'h0F, 8'h1F};
    for (int i = 0; i < 9; i++) begin
      wr(i[3:0], 8'hFF);
      rdchk(i[3:0], msk[i], "implemented bits");
      wr(i[3:0], 8'h00);
    end
    wr(1, 8'h00);
    wr(2, 8'h00);
    wr(8, 8'h13);
    idle(1);
    chk({2'b00, mon_out}, 8'h33, "monitor on outputs");
    wr(8, 8'h0D);
    idle(1);
    chk({2'b00, mon_out}, 8'h0D, "monitor off outputs");
    $display("done masks");
  endtask

  task automatic t_thresh();
    supply_mv <= 13'h0C1C;
    // 3100 mV is below the levels of codes 5 to 7 only
    for (int c = 0; c < 8; c++) begin
      wr(8, 8'h10 | c[7:0]);
      idle(2);
      rdchk(8, 8'h10 | c[7:0] | ((c >= 5) ? 8'h20 : 8'h00), "low flag");
    end
    wr(8, 8'h00);
    for (int k = 0; k < 3; k++) rdchk(8, 8'h00, "detector off");
    wr(6, 8'h00);
    supply_mv <= 13'h1388;
    $display("done thresholds");
  endtask

  task automatic t_edges();
    logic [7:0] f;
    for (int p = 0; p < 2; p++) begin
      f = p ? 8'h20 : 8'h10;
      for (int m = 0; m < 4; m++) begin
        wr(7, m[7:0] << (2 * p));
        pins[p] <= 1'b1;
        idle(2);
        rdchk(0, m[0] ? f : 8'h00, "rising edge");
        wr(0, 8'h00);
        pins[p] <= 1'b0;
        idle(2);
        rdchk(0, m[1] ? f : 8'h00, "falling edge");
        wr(0, 8'h00);
      end
    end
    wr(7, 8'h00);
    $display("done edges");
  endtask

  task automatic t_sources();
    logic [3:0] ad [0:14];
    logic [7:0] fb [0:14];
    ad = '{0, 1, 1, 2, 2, 3, 3, 4, 4, 4, 4, 5, 5, 5, 6};
    fb = '{8'h40, 8'h10, 8'h80, 8'h20, 8'h40, 8'h10, 8'h20, 8'h10, 8'h20, 8'h40, 8'h80,
           8'h10, 8'h20, 8'h40, 8'h20};
    for (int e = 0; e < 15; e++) begin
      fire(e);
      rdchk(ad[e], fb[e], "source flag");
      wr(ad[e], 8'h00);
    end
    $display("done sources");
  endtask

  task automatic t_irq();
    wr(1, 8'h01);
    fire(1);
    rdchk(1, 8'h11, "uart flag held");
    chk({7'h00, irq_req}, 8'h00, "global off blocks");
    wr(0, 8'h01);
    idle(2);
    chk({7'h00, irq_req}, 8'h01, "irq taken");
    chk({4'h0, irq_vector}, 8'h03, "uart vector");
    wr(1, 8'h10);
    idle(2);
    chk({7'h00, irq_req}, 8'h00, "enable off blocks");
    wr(1, 8'h00);
    wr(0, 8'h00);
    $display("done irq");
  endtask

  task automatic t_supply();
    wr(6, 8'h01);
    wr(2, 8'h08);
    wr(8, 8'h17);
    supply_mv <= 13'h0DAC;
    rdchk(6, 8'h01, "no early supply flag");
    idle(2 * DLY);
    rdchk(6, 8'h11, "supply flag after delay");
    rdchk(2, 8'h88, "shared flag");
    wr(8, 8'h00);
    wr(6, 8'h00);
    wr(2, 8'h00);
    supply_mv <= 13'h1388;
    $display("done supply");
  endtask

  task automatic t_sleep();
    int w;
    wr(8, 8'h17);
    wr(6, 8'h10);
    sleep_mode <= 1'b1;
    w = wake_cnt;
    supply_mv <= 13'h0DAC;
    idle(3 * DLY);
    chk(wake_cnt - w, 8'h00, "preset flag no wake");
    supply_mv <= 13'h1388;
    wr(6, 8'h00);
    idle(2);
    w = wake_cnt;
    supply_mv <= 13'h0DAC;
    idle(3 * DLY);
    chk(wake_cnt - w, 8'h01, "supply drop wakes");
    rdchk(6, 8'h10, "flag set in sleep");
    sleep_mode <= 1'b0;
    wr(8, 8'h00);
    wr(6, 8'h00);
    $display("done sleep");
  endtask

  initial begin
    repeat (16) @(posedge clk);
    rst <= 1'b0;
    t_reset();
    t_masks();
    t_thresh();
    t_edges();
    t_sources();
    t_irq();
    t_supply();
    t_sleep();
    print_verdict();
  end
endmodule
